// [ckdd_top.sv]
// clock divider distribution: registers, integer loop scalers, dividers
//
// How it works
// - doubler off: phase detector gets reference over selected divide value
// - doubler on: phase detector gets twice the reference rate
// - three-bit field picks reference divide 1, 1.5, 2, 3, 4, 6, 8
// - eight-bit feedback ratio, software keeps it within 4 to 255
// - bandwidth band follows feedback value: 4-23, 24-47, 48-255
// - feedback value may change while running, no reset needed
// - lock reported only when reference and feedback edges land in the same clock cycle
// - five output groups: four, two, two, two and one drivers
// - six channel dividers with six-bit ratios, divide 1 to 64
// - ratio fields sit in low six bits of their own registers
// - dividers reset to divide by 4, zero-delay divider to 1
// - six-bit initial phase delays first edge by half input periods
// - phase fields in low six bits of their printed registers
// - bit 6 of the ratio registers of dividers zero to four powers that divider down
// - divider zero and zero-delay divider run from first loop divider
// - bit 6 picks first or second loop divider for dividers one, two
// - bit 6 picks oscillator or first loop divider for divider three
// - divider four always runs from the integer oscillator
// - sync input high holds a divider at its initial phase
// - staged settings reach the logic only on update write of 0x01
//
// Implementation choice: the Wishbone register port.
`default_nettype none
module ckdd_top import ckdd_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ref_edge_i,
    input wire logic m0_tick_i,
    input wire logic m1_tick_i,
    input wire logic vco_tick_i,
    output logic pfd_tick_o,
    output logic fb_tick_o,
    output logic lock_o,
    output logic [2:0] band_o,
    output logic [3:0] grp0_o,
    output logic [1:0] grp1_o,
    output logic [1:0] grp2_o,
    output logic [1:0] grp3_o,
    output logic grp4_o,
    output logic zd_clk_o
);
    ////////////////////////////////////////////////////////////////////////
    // slot numbering of the register storage
    localparam logic [3:0] SL_ZD = 4'h0;
    localparam logic [3:0] SL_Q0R = 4'h1;
    localparam logic [3:0] SL_Q0P = 4'h2;
    localparam logic [3:0] SL_Q1R = 4'h3;
    localparam logic [3:0] SL_Q1P = 4'h4;
    localparam logic [3:0] SL_Q2R = 4'h5;
    localparam logic [3:0] SL_Q2P = 4'h6;
    localparam logic [3:0] SL_FB = 4'h7;
    localparam logic [3:0] SL_REF = 4'h8;
    localparam logic [3:0] SL_Q3R = 4'h9;
    localparam logic [3:0] SL_Q3P = 4'hA;
    localparam logic [3:0] SL_Q4R = 4'hB;
    localparam logic [3:0] SL_Q4P = 4'hC;
    localparam logic [3:0] SL_SYNC = 4'hD;

    typedef struct packed {
        logic [NREG-1:0][7:0] staged;
        logic [NREG-1:0][7:0] active;
        logic ack;
        logic [31:0] rdat;
        logic [4:0] refcnt;
        logic pfd;
        logic [7:0] fbcnt;
        logic fb;
    } ckdd_top_st_t;

    ckdd_top_st_t st_ff;
    ckdd_top_st_t nxt_st;

    logic [9:0] idx;
    logic [3:0] slot;
    logic req;
    logic wr;
    logic upd_wr;
    logic dbl;
    logic [2:0] rsel;
    logic [7:0] fbval;
    logic lock;
    ckdd_band_t band;
    ckdd_div_cfg_t cfg [NDIV];
    logic [NDIV-1:0] div_clk;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    function automatic logic [3:0] slot_of(input logic [9:0] a);
        case (a)
            IDX_ZD: slot_of = SL_ZD;
            IDX_Q0R: slot_of = SL_Q0R;
            IDX_Q0P: slot_of = SL_Q0P;
            IDX_Q1R: slot_of = SL_Q1R;
            IDX_Q1P: slot_of = SL_Q1P;
            IDX_Q2R: slot_of = SL_Q2R;
            IDX_Q2P: slot_of = SL_Q2P;
            IDX_FB: slot_of = SL_FB;
            IDX_REF: slot_of = SL_REF;
            IDX_Q3R: slot_of = SL_Q3R;
            IDX_Q3P: slot_of = SL_Q3P;
            IDX_Q4R: slot_of = SL_Q4R;
            IDX_Q4P: slot_of = SL_Q4P;
            IDX_SYNC: slot_of = SL_SYNC;
            default: slot_of = SL_NONE;
        endcase
    endfunction

    assign idx = wb_adr_i[11:2];
    assign slot = slot_of(idx);
    assign req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign upd_wr = wr & (idx == IDX_UPDATE) & (wb_dat_i[7:0] == UPDATE_CMD);

    ////////////////////////////////////////////////////////////////////////
    // decoded active settings
    assign dbl = st_ff.active[SL_REF][DBL_BIT];
    assign rsel = st_ff.active[SL_REF][RDIV_MSB:RDIV_LSB];
    assign fbval = st_ff.active[SL_FB];

    always_comb begin
        if (fbval <= BAND_LO_MAX) begin
            band = BW_3M5;
        end else if (fbval <= BAND_MID_MAX) begin
            band = BW_1M75;
        end else begin
            band = BW_1M0;
        end
    end

    // ratio, phase, power down and source fields
    always_comb begin
        for (int i = 0; i < NDIV; i++) begin
            cfg[i] = '0;
        end
        cfg[0].ratio = st_ff.active[SL_Q0R][FLD_MSB:FLD_LSB];
        cfg[1].ratio = st_ff.active[SL_Q1R][FLD_MSB:FLD_LSB];
        cfg[2].ratio = st_ff.active[SL_Q2R][FLD_MSB:FLD_LSB];
        cfg[3].ratio = st_ff.active[SL_Q3R][FLD_MSB:FLD_LSB];
        cfg[4].ratio = st_ff.active[SL_Q4R][FLD_MSB:FLD_LSB];
        cfg[5].ratio = st_ff.active[SL_ZD][FLD_MSB:FLD_LSB];
        cfg[0].phase = st_ff.active[SL_Q0P][FLD_MSB:FLD_LSB];
        cfg[1].phase = st_ff.active[SL_Q1P][FLD_MSB:FLD_LSB];
        cfg[2].phase = st_ff.active[SL_Q2P][FLD_MSB:FLD_LSB];
        cfg[3].phase = st_ff.active[SL_Q3P][FLD_MSB:FLD_LSB];
        cfg[4].phase = st_ff.active[SL_Q4P][FLD_MSB:FLD_LSB];
        cfg[5].phase = st_ff.active[SL_ZD][FLD_MSB:FLD_LSB];
        cfg[0].pd = st_ff.active[SL_Q0R][PD_BIT];
        cfg[1].pd = st_ff.active[SL_Q1R][PD_BIT];
        cfg[2].pd = st_ff.active[SL_Q2R][PD_BIT];
        cfg[3].pd = st_ff.active[SL_Q3R][PD_BIT];
        cfg[4].pd = st_ff.active[SL_Q4R][PD_BIT];
        cfg[0].tick = m0_tick_i;
        cfg[5].tick = m0_tick_i;
        cfg[1].tick = st_ff.active[SL_Q1P][SRC_BIT] ? m1_tick_i : m0_tick_i;
        cfg[2].tick = st_ff.active[SL_Q2P][SRC_BIT] ? m1_tick_i : m0_tick_i;
        cfg[3].tick = st_ff.active[SL_Q3P][SRC_BIT] ? m0_tick_i : vco_tick_i;
        cfg[4].tick = vco_tick_i;
        for (int i = 0; i < NDIV; i++) begin
            cfg[i].sync = st_ff.active[SL_SYNC][i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file, scalers and feedback divider
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = req;
        if (req && !wb_we_i) begin
            if (idx == IDX_STATUS) begin
                nxt_st.rdat = {28'h0000000, band, lock};
            end else if (slot != SL_NONE) begin
                nxt_st.rdat = {24'h000000, st_ff.staged[slot]};
            end else begin
                nxt_st.rdat = 32'h00000000;
            end
        end
        if (wr && slot != SL_NONE) begin
            nxt_st.staged[slot] = wb_dat_i[7:0];
        end
        if (upd_wr) begin
            nxt_st.active = st_ff.staged;
        end
        nxt_st.pfd = 1'b0;
        if (ref_edge_i) begin
            if (dbl) begin
                nxt_st.pfd = 1'b1;
                nxt_st.refcnt = 5'h00;
            end else if (st_ff.refcnt >= REF_HALF[rsel] - 5'h01) begin
                nxt_st.pfd = 1'b1;
                nxt_st.refcnt = 5'h00;
            end else begin
                nxt_st.refcnt = st_ff.refcnt + 5'h01;
            end
        end
        nxt_st.fb = 1'b0;
        if (vco_tick_i) begin
            if (st_ff.fbcnt + 8'h01 >= fbval) begin
                nxt_st.fb = 1'b1;
                nxt_st.fbcnt = 8'h00;
            end else begin
                nxt_st.fbcnt = st_ff.fbcnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_ff <= '0;
            st_ff.staged[SL_Q0R] <= RST_QR;
            st_ff.staged[SL_Q1R] <= RST_QR;
            st_ff.staged[SL_Q2R] <= RST_QR;
            st_ff.staged[SL_Q3R] <= RST_QR;
            st_ff.staged[SL_Q4R] <= RST_QR;
            st_ff.staged[SL_ZD] <= RST_ZD;
            st_ff.staged[SL_FB] <= RST_FB;
            st_ff.active[SL_Q0R] <= RST_QR;
            st_ff.active[SL_Q1R] <= RST_QR;
            st_ff.active[SL_Q2R] <= RST_QR;
            st_ff.active[SL_Q3R] <= RST_QR;
            st_ff.active[SL_Q4R] <= RST_QR;
            st_ff.active[SL_ZD] <= RST_ZD;
            st_ff.active[SL_FB] <= RST_FB;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock detector and channel dividers
    ckdd_lock_det u_lock (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pfd_i(st_ff.pfd),
        .fb_i(st_ff.fb),
        .lock_o(lock)
    );

    for (genvar g = 0; g < NDIV; g++) begin : g_div
        ckdd_chan_div u_div (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .cfg_i(cfg[g]),
            .clk_o(div_clk[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = st_ff.rdat;
    assign pfd_tick_o = st_ff.pfd;
    assign fb_tick_o = st_ff.fb;
    assign lock_o = lock;
    assign band_o = band;
    assign grp0_o = {4{div_clk[0]}};
    assign grp1_o = {2{div_clk[1]}};
    assign grp2_o = {2{div_clk[2]}};
    assign grp3_o = {2{div_clk[3]}};
    assign grp4_o = div_clk[4];
    assign zd_clk_o = div_clk[5];

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_upd_write;
        upd_wr ##1 1'b1;
    endsequence
    property p_update;
        @(posedge clk_i) disable iff (!rstn_i)
        s_upd_write |-> st_ff.active == $past(st_ff.staged);
    endproperty
    a_update: assert property (p_update) else $error("update lost");
    property p_no_update;
        @(posedge clk_i) disable iff (!rstn_i)
        !upd_wr |=> $stable(st_ff.active);
    endproperty
    a_no_update: assert property (p_no_update) else $error("early apply");
    property p_band;
        @(posedge clk_i) disable iff (!rstn_i)
        (fbval > BAND_MID_MAX |-> band_o == BW_1M0) and
        (fbval <= BAND_LO_MAX |-> band_o == BW_3M5);
    endproperty
    a_band: assert property (p_band) else $error("wrong band");
    property p_doubler;
        @(posedge clk_i) disable iff (!rstn_i)
        dbl && ref_edge_i |=> pfd_tick_o;
    endproperty
    a_doubler: assert property (p_doubler) else $error("doubler miss");
    property p_refdiv;
        @(posedge clk_i) disable iff (!rstn_i)
        !dbl && ref_edge_i && st_ff.refcnt < REF_HALF[rsel] - 5'h01
        |=> !pfd_tick_o;
    endproperty
    a_refdiv: assert property (p_refdiv) else $error("early pfd");
    property p_fb;
        @(posedge clk_i) disable iff (!rstn_i)
        vco_tick_i && st_ff.fbcnt + 8'h01 >= fbval
        |=> fb_tick_o && st_ff.fbcnt == 8'h00;
    endproperty
    a_fb: assert property (p_fb) else $error("feedback miss");
    property p_src3;
        @(posedge clk_i) disable iff (!rstn_i)
        !st_ff.active[SL_Q3P][SRC_BIT] |-> cfg[3].tick == vco_tick_i;
    endproperty
    a_src3: assert property (p_src3) else $error("divider three src");
endmodule // ckdd_top
`default_nettype wire

// [ckdd_pkg.sv]
// package: constants and types for the clock divider distribution block
`default_nettype none
package ckdd_pkg;
    // bus timing and lock window
    localparam int CLK_PERIOD_PS = 5000;
    localparam int LOCK_WIN_PS = 3250;
    localparam int LOCK_CYC_RAW = LOCK_WIN_PS / CLK_PERIOD_PS;
    localparam logic [3:0] LOCK_CYC = (LOCK_CYC_RAW < 1) ? 4'h1 :
        4'(LOCK_CYC_RAW);
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_UPDATE = 10'h00F;
    localparam logic [9:0] IDX_SYNC = 10'h0F0;
    localparam logic [9:0] IDX_STATUS = 10'h0F1;
    localparam logic [9:0] IDX_ZD = 10'h110;
    localparam logic [9:0] IDX_Q0R = 10'h140;
    localparam logic [9:0] IDX_Q0P = 10'h141;
    localparam logic [9:0] IDX_Q1R = 10'h146;
    localparam logic [9:0] IDX_Q1P = 10'h147;
    localparam logic [9:0] IDX_Q2R = 10'h14A;
    localparam logic [9:0] IDX_Q2P = 10'h14B;
    localparam logic [9:0] IDX_FB = 10'h201;
    localparam logic [9:0] IDX_REF = 10'h202;
    localparam logic [9:0] IDX_Q3R = 10'h240;
    localparam logic [9:0] IDX_Q3P = 10'h241;
    localparam logic [9:0] IDX_Q4R = 10'h244;
    localparam logic [9:0] IDX_Q4P = 10'h245;
    localparam logic [7:0] UPDATE_CMD = 8'h01;
    // storage slots
    localparam int NREG = 14;
    localparam int NDIV = 6;
    localparam logic [3:0] SL_NONE = 4'hF;
    // field positions
    localparam int FLD_LSB = 0;
    localparam int FLD_MSB = 5;
    localparam int PD_BIT = 6;
    localparam int SRC_BIT = 6;
    localparam int DBL_BIT = 0;
    localparam int RDIV_LSB = 1;
    localparam int RDIV_MSB = 3;
    // reset values: ratio field holds divide value minus one
    localparam logic [7:0] RST_ZD = 8'h00;
    localparam logic [7:0] RST_QR = 8'h03;
    localparam logic [7:0] RST_FB = 8'h20;
    localparam logic [7:0] RST_OTHER = 8'h00;
    // loop bandwidth band limits
    localparam logic [7:0] BAND_LO_MAX = 8'h17;
    localparam logic [7:0] BAND_MID_MAX = 8'h2F;
    // reference scaler periods in reference half periods
    localparam logic [4:0] REF_HALF [0:7] = '{5'h02, 5'h03, 5'h04,
        5'h06, 5'h08, 5'h0C, 5'h10, 5'h10};
    typedef enum logic [2:0] {
        BW_3M5 = 3'b001,
        BW_1M75 = 3'b010,
        BW_1M0 = 3'b100
    } ckdd_band_t;
    typedef struct packed {
        logic [5:0] ratio;
        logic [5:0] phase;
        logic pd;
        logic sync;
        logic tick;
    } ckdd_div_cfg_t;
endpackage
`default_nettype wire

// [ckdd_chan_div.sv]
// channel divider: ratio, initial phase, power down and sync hold
`default_nettype none
module ckdd_chan_div import ckdd_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire ckdd_div_cfg_t cfg_i,
    output logic clk_o
);
    typedef struct packed {
        logic [5:0] cnt;
        logic [5:0] dly;
        logic halt;
        logic out;
    } ckdd_dv_st_t;
    ckdd_dv_st_t st_ff;
    ckdd_dv_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.halt = cfg_i.pd | (st_ff.halt & ~cfg_i.sync);
        if (cfg_i.sync | nxt_st.halt) begin
            nxt_st.cnt = 6'h00;
            nxt_st.dly = cfg_i.phase;
            nxt_st.out = 1'b0;
        end else if (cfg_i.tick) begin
            if (st_ff.dly != 6'h00) begin
                nxt_st.dly = st_ff.dly - 6'h01;
            end else if (st_ff.cnt == cfg_i.ratio) begin
                nxt_st.cnt = 6'h00;
                nxt_st.out = ~st_ff.out;
            end else begin
                nxt_st.cnt = st_ff.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign clk_o = st_ff.out;

    property p_sync_low;
        @(posedge clk_i) disable iff (!rstn_i)
        cfg_i.sync |=> !clk_o;
    endproperty
    a_sync_low: assert property (p_sync_low) else $error("sync not low");
    property p_pd_low;
        @(posedge clk_i) disable iff (!rstn_i)
        cfg_i.pd ##1 !cfg_i.sync |-> !clk_o;
    endproperty
    a_pd_low: assert property (p_pd_low) else $error("pd not low");
    property p_phase_low;
        @(posedge clk_i) disable iff (!rstn_i)
        st_ff.dly != 6'h00 |-> !clk_o;
    endproperty
    a_phase_low: assert property (p_phase_low) else $error("early edge");
    property p_toggle;
        @(posedge clk_i) disable iff (!rstn_i)
        cfg_i.tick && !cfg_i.sync && !cfg_i.pd && !st_ff.halt &&
        st_ff.dly == 6'h00 && st_ff.cnt == cfg_i.ratio
        |=> clk_o != $past(clk_o);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");
endmodule // ckdd_chan_div
`default_nettype wire

// [ckdd_lock_det.sv]
// phase error lock detector for the integer loop
`default_nettype none
module ckdd_lock_det import ckdd_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic pfd_i,
    input wire logic fb_i,
    output logic lock_o
);
    typedef struct packed {
        logic pend_ref;
        logic pend_fb;
        logic [3:0] cnt;
        logic lock;
    } ckdd_ld_st_t;
    ckdd_ld_st_t st_ff;
    ckdd_ld_st_t nxt_st;
    logic pend;
    // elapsed cycles, one bit wider so a saturated count cannot wrap
    logic [4:0] age;

    always_comb begin
        nxt_st = st_ff;
        pend = st_ff.pend_ref | st_ff.pend_fb;
        age = {1'b0, st_ff.cnt} + 5'h01;
        if (pend && st_ff.cnt != 4'hF) begin
            nxt_st.cnt = st_ff.cnt + 4'h1;
        end
        if (pfd_i & fb_i) begin
            nxt_st.lock = 1'b1;
            nxt_st.pend_ref = 1'b0;
            nxt_st.pend_fb = 1'b0;
        end else if ((pfd_i & st_ff.pend_fb) | (fb_i & st_ff.pend_ref)) begin
            nxt_st.lock = age < {1'b0, LOCK_CYC};
            nxt_st.pend_ref = 1'b0;
            nxt_st.pend_fb = 1'b0;
        end else if (pfd_i | fb_i) begin
            // a repeated edge on one side is a slipped cycle
            if (pend) begin
                nxt_st.lock = 1'b0;
            end
            nxt_st.pend_ref = pfd_i;
            nxt_st.pend_fb = fb_i;
            nxt_st.cnt = 4'h0;
        end else if (pend && age >= {1'b0, LOCK_CYC}) begin
            nxt_st.lock = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign lock_o = st_ff.lock;

    property p_lock_same;
        @(posedge clk_i) disable iff (!rstn_i)
        pfd_i && fb_i |=> lock_o;
    endproperty
    a_lock_same: assert property (p_lock_same) else $error("no lock");
    property p_lock_late;
        @(posedge clk_i) disable iff (!rstn_i)
        st_ff.pend_ref && fb_i && !pfd_i &&
        age >= {1'b0, LOCK_CYC} |=> !lock_o;
    endproperty
    a_lock_late: assert property (p_lock_late) else $error("late lock");
endmodule // ckdd_lock_det
`default_nettype wire

// [ckdd_tb_top.sv]
// self-checking testbench for the clock divider distribution block
`default_nettype none
`define CHK(n, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("[FAIL] %s exp %0h got %0h", n, e, g); \
    end \
end
module ckdd_tb_top import ckdd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack, pfd, fb, lock, g4, zd, both_q, one_q, one_q2;
    // tick inputs: reference, first loop, second loop, oscillator
    logic [3:0] tk = 4'h0;
    logic [3:0] g0;
    logic [1:0] g1, g2, g3;
    logic [2:0] band;
    logic [7:0] e;
    logic [7:0] expq[$];
    logic [5:0] prv = 6'h00;
    int err_count = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    int c_pfd = 0;
    int c_fb = 0;
    int c_g[6];
    integer seed = 32'hC569BD69;
    logic [9:0] idxs[13] = '{IDX_ZD, IDX_Q0R, IDX_Q0P, IDX_Q1R, IDX_Q1P,
        IDX_Q2R, IDX_Q2P, IDX_FB, IDX_REF, IDX_Q3R, IDX_Q3P, IDX_Q4R,
        IDX_Q4P};
    logic [7:0] rstv[13] = '{8'h00, 8'h03, 8'h00, 8'h03, 8'h00, 8'h03,
        8'h00, 8'h20, 8'h00, 8'h03, 8'h00, 8'h03, 8'h00};
    logic [7:0] fbv[7] = '{8'h04, 8'h17, 8'h18, 8'h2F, 8'h30, 8'hFF, 8'h04};
    logic [7:0] pexp[9] = '{8'h30, 8'h18, 8'h10, 8'h0C, 8'h08, 8'h06,
        8'h04, 8'h03, 8'h03};
    wire logic [5:0] cur = {zd, g4, g3[0], g2[0], g1[0], g0[0]};
    wire logic rep_ok = g0 === {4{g0[0]}} && g1 === {2{g1[0]}} &&
        g2 === {2{g2[0]}} && g3 === {2{g3[0]}};

    ckdd_top ckdd_top_i (.clk_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ref_edge_i(tk[3]), .m0_tick_i(tk[2]), .m1_tick_i(tk[1]),
        .vco_tick_i(tk[0]), .pfd_tick_o(pfd), .fb_tick_o(fb),
        .lock_o(lock), .band_o(band), .grp0_o(g0), .grp1_o(g1),
        .grp2_o(g2), .grp3_o(g3), .grp4_o(g4), .zd_clk_o(zd));

    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    // counts within one either way: counter phase after update is free
    function automatic logic near(input int x, input int g);
        return g + 1 >= x && g <= x + 1;
    endfunction

    function automatic logic [2:0] bexp(input logic [7:0] v);
        if (v <= BAND_LO_MAX)
            return BW_3M5;
        if (v <= BAND_MID_MAX)
            return BW_1M75;
        return BW_1M0;
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [9:0] idx,
            input logic [7:0] d, input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= {idx, 2'b00};
        wdat <= {24'($random(seed)), d};
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'hF);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] x);
        expq.push_back(x);
        bus(1'b0, idx, 8'h00, 4'hF);
    endtask

    task automatic upd();
        wr(IDX_UPDATE, UPDATE_CMD);
        @(posedge clk);
    endtask

    task automatic pulse(input logic [3:0] m, input int n);
        repeat (n) begin
            @(posedge clk);
            tk <= m;
            @(posedge clk);
            tk <= 4'h0;
        end
        repeat (3) @(posedge clk);
    endtask

    task automatic dv(input logic [3:0] m, input int ex[6]);
        c_g = '{default: 0};
        pulse(m, 48);
        foreach (ex[i])
            `CHK("div toggles", 1'b1, near(ex[i], c_g[i]))
    endtask

    ////////////////////////////////////////////////////////////////////
    // result watcher: read data, lock, tick and toggle counts
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 40000) begin
            err_count++;
            report_and_stop();
        end
        if (ack === 1'b1 && we === 1'b0) begin
            e = expq.pop_front();
            `CHK("read data", 32'(e), rdat)
        end
        if (both_q) `CHK("lock joint", 1'b1, lock)
        // a lone edge clears lock only once its window has run out
        if (one_q2) `CHK("lock lone", 1'b0, lock)
        `CHK("group copies", 1'b1, rep_ok)
        both_q <= pfd === 1'b1 && fb === 1'b1;
        one_q <= (pfd === 1'b1) != (fb === 1'b1);
        one_q2 <= one_q;
        if (pfd === 1'b1)
            c_pfd++;
        if (fb === 1'b1)
            c_fb++;
        for (int i = 0; i < 6; i++)
            if (cur[i] !== prv[i])
                c_g[i]++;
        prv <= cur;
    end

    initial begin
        logic [7:0] v;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        foreach (idxs[i]) rd(idxs[i], rstv[i]);
        rd(10'h3FF, 8'h00);
        rd(IDX_STATUS, 8'h04);
        `CHK("band reset", BW_1M75, band)
        foreach (idxs[i]) begin
            v = 8'($random(seed));
            wr(idxs[i], v);
            bus(1'b1, idxs[i], ~v, 4'hE);
            rd(idxs[i], v);
        end
        `CHK("band staged", BW_1M75, band)
        foreach (idxs[i]) wr(idxs[i], rstv[i]);
        upd();
        fbv[0] = 8'(4 + ({$random(seed)} % 252));
        foreach (fbv[i]) begin
            wr(IDX_FB, fbv[i]);
            upd();
            `CHK("band", bexp(fbv[i]), band)
        end
        wr(IDX_FB, 8'h30);
        wr(IDX_UPDATE, 8'h02);
        @(posedge clk);
        `CHK("band no update", BW_3M5, band)
        upd();
        c_fb = 0;
        dv(4'b0001, '{0, 0, 0, 12, 12, 0});
        `CHK("fb count", 1'b1, near(1, c_fb))
        wr(IDX_FB, 8'h06);
        upd();
        c_fb = 0;
        pulse(4'b0001, 48);
        `CHK("fb count", 1'b1, near(8, c_fb))
        for (int i = 0; i < 9; i++) begin
            wr(IDX_REF, i == 0 ? 8'h01 : 8'((i - 1) * 2));
            upd();
            c_pfd = 0;
            pulse(4'b1000, 48);
            `CHK("pfd", 1'b1, near(pexp[i], c_pfd))
        end
        wr(IDX_REF, 8'h01);
        wr(IDX_FB, 8'h04);
        upd();
        pulse(4'b1001, 16);
        dv(4'b0100, '{12, 12, 12, 0, 0, 48});
        wr(IDX_Q1P, 8'h40);
        wr(IDX_Q2P, 8'h40);
        wr(IDX_Q3P, 8'h40);
        wr(IDX_Q4R, 8'h43);
        wr(IDX_SYNC, 8'h01);
        upd();
        dv(4'b0100, '{0, 0, 0, 12, 0, 48});
        dv(4'b0010, '{0, 12, 12, 0, 0, 0});
        dv(4'b0001, '{0, 0, 0, 0, 0, 0});
        `CHK("held outputs low", 2'b00, {g4, g0[0]})
        wr(IDX_Q0P, 8'h18);
        upd();
        wr(IDX_SYNC, 8'h00);
        upd();
        dv(4'b0100, '{6, 0, 0, 12, 0, 48});
        report_and_stop();
    end
endmodule // ckdd_tb_top
`default_nettype wire
